// ==== sild_params.svh ====
// constants of the serial-in latched driver
`ifndef SILD_PARAMS_SVH
`define SILD_PARAMS_SVH
`define SILD_STAGES      10
`define SILD_FIFO_DEPTH  8
`define SILD_SYNC_RST    1'h0
`define SILD_REG_RST     10'h000
`endif

// ==== sild_pkg.sv ====
// types of the serial-in latched driver
package sild_pkg;
   // pin group as driven by the controller
   typedef struct packed {
      logic sclk;
      logic ser_in;
      logic load;
      logic blank;
   } sild_pins_s;
endpackage

// ==== sild_driver.sv ====
// serial-in latched driver: pin sampling, bit FIFO, shift stages, latches, blanking
`timescale 1ns/100ps
`include "sild_params.svh"

// ----------------------------------------------------------------------------
// bit FIFO
// ----------------------------------------------------------------------------
module sild_fifo
   import sild_pkg::*;
#(
   parameter int WIDTH = 1,
   parameter int DEPTH = `SILD_FIFO_DEPTH
)(
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             in_valid,
   output      logic             in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output      logic             out_valid,
   input  wire logic             out_ready,
   output      logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wr_ptr_r;
   logic [AW-1:0]    rd_ptr_r;
   logic [AW:0]      count_r;
   logic             push;
   logic             pop;

   function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
      ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   assign in_ready  = (count_r != (AW+1)'(DEPTH));
   assign out_valid = (count_r != '0);
   assign out_data  = mem_r[rd_ptr_r];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem_r[wr_ptr_r] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= ptr_inc(wr_ptr_r);
         end
         if (pop) begin
            rd_ptr_r <= ptr_inc(rd_ptr_r);
         end
         count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// ----------------------------------------------------------------------------
// top
// ----------------------------------------------------------------------------
module sild_driver
   import sild_pkg::*;
#(
   parameter int STAGES     = `SILD_STAGES,
   parameter int FIFO_DEPTH = `SILD_FIFO_DEPTH
)(
   input  wire logic              sys_clk,
   input  wire logic              nrst,
   input  wire sild_pins_s        pins,
   output      logic [STAGES-1:0] drv_out,
   output      logic              ser_out,
   output      logic              shift_ready
);
   logic              rst_meta_r;
   logic              rst_n_r;
   sild_pins_s        pins_meta_r;
   sild_pins_s        pins_sync_r;
   logic              sclk_prev_r;
   logic              sclk_rise;
   logic              bit_valid;
   logic              bit_data;
   logic              bit_pop;
   logic [STAGES-1:0] stage_r;
   logic [STAGES-1:0] stage_nxt;
   logic [STAGES-1:0] latch_r;
   logic [STAGES-1:0] out_r;

   // ----------------------------------------------------------------------
   // reset release and pin sampling
   // ----------------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rst_meta_r <= `SILD_SYNC_RST;
         rst_n_r    <= `SILD_SYNC_RST;
      end else begin
         rst_meta_r <= 1'h1;
         rst_n_r    <= rst_meta_r;
      end
   end

   // the shift clock is a plain pin here, so it is sampled like data
   always_ff @(posedge sys_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         pins_meta_r <= '0;
         pins_sync_r <= '0;
         sclk_prev_r <= 1'h0;
      end else begin
         pins_meta_r <= pins;
         pins_sync_r <= pins_meta_r;
         sclk_prev_r <= pins_sync_r.sclk;
      end
   end

   // data and clock share the same two-stage delay, so setup at the pin
   // carries over to the sampled edge
   assign sclk_rise = pins_sync_r.sclk && !sclk_prev_r;

   // ----------------------------------------------------------------------
   // bit FIFO between edge capture and shift stages
   // ----------------------------------------------------------------------
   sild_fifo #(
      .WIDTH (1),
      .DEPTH (FIFO_DEPTH)
   ) sild_fifo_i (
      .clk       (sys_clk),
      .rst_n     (rst_n_r),
      .in_valid  (sclk_rise),
      .in_ready  (shift_ready),
      .in_data   (pins_sync_r.ser_in),
      .out_valid (bit_valid),
      // drain always ready: the FIFO only absorbs the skew between edge and shift
      .out_ready (1'h1),
      .out_data  (bit_data)
   );

   assign bit_pop = bit_valid;

   // ----------------------------------------------------------------------
   // shift stages
   // ----------------------------------------------------------------------
   always_comb begin
      stage_nxt = stage_r;
      if (bit_pop) begin
         stage_nxt = {stage_r[STAGES-2:0], bit_data};
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         stage_r <= STAGES'(`SILD_REG_RST);
      end else begin
         stage_r <= stage_nxt;
      end
   end

   assign ser_out = stage_r[STAGES-1];

   // ----------------------------------------------------------------------
   // latches and blanking
   // ----------------------------------------------------------------------
   // blanking is deliberately absent from the latch enable
   always_ff @(posedge sys_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         latch_r <= STAGES'(`SILD_REG_RST);
      end else if (pins_sync_r.load) begin
         latch_r <= stage_r;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         out_r <= STAGES'(`SILD_REG_RST);
      end else if (pins_sync_r.blank) begin
         out_r <= '0;
      end else begin
         out_r <= latch_r;
      end
   end

   assign drv_out = out_r;

   // ----------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------
   property p_first_stage;
      @(posedge sys_clk) disable iff (!rst_n_r)
      bit_pop |=> stage_r[0] == $past(bit_data);
   endproperty
   a_first_stage: assert property (p_first_stage)
      else $error("first stage missed the serial bit");

   property p_stage_move;
      @(posedge sys_clk) disable iff (!rst_n_r)
      bit_pop |=> stage_r[STAGES-1:1] == $past(stage_r[STAGES-2:0]);
   endproperty
   a_stage_move: assert property (p_stage_move)
      else $error("stages did not move toward cascade output");

   property p_cascade;
      @(posedge sys_clk) disable iff (!rst_n_r)
      bit_pop |=> ser_out == $past(stage_r[STAGES-2]);
   endproperty
   a_cascade: assert property (p_cascade)
      else $error("cascade output not last stage");

   property p_follow;
      @(posedge sys_clk) disable iff (!rst_n_r)
      pins_sync_r.load |=> latch_r == $past(stage_r);
   endproperty
   a_follow: assert property (p_follow)
      else $error("latch did not follow stage while loading");

   property p_hold;
      @(posedge sys_clk) disable iff (!rst_n_r)
      !pins_sync_r.load ##1 !pins_sync_r.load |=> $stable(latch_r);
   endproperty
   a_hold: assert property (p_hold)
      else $error("latch changed while load low");

   property p_blank_off;
      @(posedge sys_clk) disable iff (!rst_n_r)
      pins_sync_r.blank |=> drv_out == '0;
   endproperty
   a_blank_off: assert property (p_blank_off)
      else $error("output high while blanked");

   property p_blank_keeps;
      @(posedge sys_clk) disable iff (!rst_n_r)
      pins_sync_r.blank && !pins_sync_r.load |=> latch_r == $past(latch_r);
   endproperty
   a_blank_keeps: assert property (p_blank_keeps)
      else $error("blanking disturbed latch");

   property p_unblank;
      @(posedge sys_clk) disable iff (!rst_n_r)
      !pins_sync_r.blank |=> drv_out == $past(latch_r);
   endproperty
   a_unblank: assert property (p_unblank)
      else $error("output does not match latch");

   property p_idle;
      @(posedge sys_clk) disable iff (!rst_n_r)
      !bit_pop |=> $stable(stage_r) && $stable(ser_out);
   endproperty
   a_idle: assert property (p_idle)
      else $error("stages moved without a clock edge");

   property p_edge_to_shift;
      @(posedge sys_clk) disable iff (!rst_n_r)
      sclk_rise && shift_ready |-> ##1 bit_pop;
   endproperty
   a_edge_to_shift: assert property (p_edge_to_shift)
      else $error("sampled clock edge did not reach stages");

   property p_no_drop;
      @(posedge sys_clk) disable iff (!rst_n_r)
      sclk_rise |-> shift_ready;
   endproperty
   a_no_drop: assert property (p_no_drop)
      else $error("sampled clock edge found the bit FIFO full");

   // end to end: the bit seen with the edge lands in stage 0 two cycles on
   property p_pin_to_stage;
      @(posedge sys_clk) disable iff (!rst_n_r)
      sclk_rise |=> ##1 stage_r[0] == $past(pins_sync_r.ser_in, 2);
   endproperty
   a_pin_to_stage: assert property (p_pin_to_stage)
      else $error("serial bit lost between pin and first stage");

   property p_shift_needs_edge;
      @(posedge sys_clk) disable iff (!rst_n_r)
      bit_pop |-> $past(sclk_rise);
   endproperty
   a_shift_needs_edge: assert property (p_shift_needs_edge)
      else $error("shift without a preceding clock edge");

   property p_blank_load;
      @(posedge sys_clk) disable iff (!rst_n_r)
      pins_sync_r.blank && pins_sync_r.load |=> latch_r == $past(stage_r);
   endproperty
   a_blank_load: assert property (p_blank_load)
      else $error("blanking blocked latch loading");

   property p_steady;
      @(posedge sys_clk) disable iff (!rst_n_r)
      !pins_sync_r.blank && !pins_sync_r.load ##1 !pins_sync_r.blank |=> $stable(drv_out);
   endproperty
   a_steady: assert property (p_steady)
      else $error("output moved while latch held and unblanked");
endmodule

// ==== sild_host.sv ====
// host controller model driving the driver's pins
`timescale 1ns/100ps
// ------
// host
// ------
module sild_host
   import sild_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       go,
   input  wire logic [9:0] word,
   input  wire logic       load_in,
   input  wire logic       blank_in,
   output      logic       busy,
   output      sild_pins_s pins
);
   logic sclk_q;
   logic ser_q;
   initial begin
      busy = 1'h0;
      sclk_q = 1'h0;
      ser_q = 1'h0;
   end
   // shifting with latches open must stay blanked
   assign pins = '{sclk: sclk_q, ser_in: ser_q, load: load_in,
                   blank: blank_in | (busy & load_in)};
   // msb first, 800 ns link period; data held 400 ns around each rise
   always @(posedge sys_clk) begin
      if (go && !busy) begin
         busy = 1'h1;
         for (int i = 9; i >= 0; i--) begin
            #1 ser_q = word[i];
            repeat (4) @(posedge sys_clk);
            #1 sclk_q = 1'h1;
            repeat (4) @(posedge sys_clk);
            #1 sclk_q = 1'h0;
         end
         // released line: no pull, so show the inverse of the last bit
         ser_q = ~ser_q;
         busy = 1'h0;
      end
   end
endmodule

// ==== tb_sild_driver.sv ====
// self-checking bench of the serial-in latched driver
`timescale 1ns/100ps
// ------
// bench
// ------
module tb_sild_driver import sild_pkg::*;;
   logic       sys_clk;
   logic       nrst;
   logic       go;
   logic [9:0] word;
   logic       load;
   logic       blank;
   logic       busy;
   sild_pins_s pins;
   logic [9:0] drv_out;
   logic       ser_out;
   logic       shift_ready;
   int         err_count = 0;
   int         n_tests = 0;

   sild_host sild_host_i (.sys_clk(sys_clk), .go(go), .word(word), .load_in(load),
      .blank_in(blank), .busy(busy), .pins(pins));
   sild_driver sild_driver_i (.sys_clk(sys_clk), .nrst(nrst), .pins(pins),
      .drv_out(drv_out), .ser_out(ser_out), .shift_ready(shift_ready));

   initial begin
      sys_clk = 1'h0;
      forever #50 sys_clk = ~sys_clk;
   end

   task automatic stop_test();
      if (err_count == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input logic [9:0] exp, input logic [9:0] got);
      n_tests++;
      if (got !== exp) begin
         $display("mismatch t=%0t exp=%h got=%h", $time, exp, got);
         err_count++;
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic frame(input logic [9:0] w);
      int k;
      word = w;
      go = 1'h1;
      tick(1);
      go = 1'h0;
      for (k = 0; k < 300 && busy === 1'h1; k++) tick(1);
      if (k == 300) begin
         err_count++;
         stop_test();
      end
      tick(6);
   endtask

   task automatic t_shift_held();
      load = 1'h0;
      frame(10'h2B5);
      chk(10'h000, drv_out);
      chk(10'h001, {9'h000, ser_out});
      chk(10'h001, {9'h000, shift_ready});
      tick(20);
      chk(10'h001, {9'h000, ser_out});
   endtask

   task automatic t_latch_open();
      load = 1'h1;
      tick(6);
      chk(10'h2B5, drv_out);
      load = 1'h0;
      tick(6);
      frame(10'h14A);
      chk(10'h2B5, drv_out);
      chk(10'h000, {9'h000, ser_out});
   endtask

   task automatic t_blanking();
      blank = 1'h1;
      tick(6);
      chk(10'h000, drv_out);
      blank = 1'h0;
      tick(6);
      chk(10'h2B5, drv_out);
      blank = 1'h1;
      load = 1'h1;
      tick(6);
      chk(10'h000, drv_out);
      load = 1'h0;
      tick(6);
      blank = 1'h0;
      tick(6);
      chk(10'h14A, drv_out);
   endtask

   task automatic t_transparent();
      load = 1'h1;
      frame(10'h3C3);
      chk(10'h3C3, drv_out);
      load = 1'h0;
   endtask

   task automatic t_reset();
      nrst = 1'h0;
      tick(2);
      chk(10'h000, drv_out);
      chk(10'h000, {9'h000, ser_out});
      chk(10'h001, {9'h000, shift_ready});
      nrst = 1'h1;
      tick(5);
      chk(10'h000, drv_out);
      load = 1'h1;
      frame(10'h2B5);
      chk(10'h2B5, drv_out);
      chk(10'h001, {9'h000, ser_out});
      load = 1'h0;
   endtask

   initial begin
      nrst = 1'h0;
      go = 1'h0;
      word = 10'h000;
      load = 1'h0;
      blank = 1'h0;
      tick(5);
      nrst = 1'h1;
      tick(5);
      t_shift_held();
      t_latch_open();
      t_blanking();
      t_transparent();
      t_reset();
      stop_test();
   end
endmodule
